//--- design/pressure_sensor_spi_command_port.sv
`timescale 1ns/1ps
`include "sensor_regs.svh"
// spi command port: link logic on sclk, command execution on clk_sys
module pressure_sensor_spi_command_port #(
    parameter int           CONV_BASE_CYCLES = 2048,
    // calibration image; contents arbitrary, word 0 at bits 15:0
    parameter logic [127:0] PROM_IMAGE =
        128'h1234_5678_9abc_def0_0fed_cba9_8765_4321
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        sclk,
    input  wire logic        device_select_n,
    input  wire logic        sdi,
    input  wire logic        protocol_pick,
    input  wire logic [23:0] pressure_sample,
    input  wire logic [23:0] temperature_sample,
    output logic             sdo,
    output logic             result_valid,
    output logic             conversion_busy
);
    initial begin
        if (CONV_BASE_CYCLES < 1) begin
            $error("CONV_BASE_CYCLES must be at least 1");
        end
    end

    // calibration memory, written only on clk_sys
    sensor_pkg::prom_word_t prom [`PROM_WORDS];
    // last conversion result, written only on clk_sys
    sensor_pkg::adc_word_t  adc_word;

    // ---------------- link domain (sclk) ----------------

    logic [5:0]  bit_cnt;          // bits received this frame
    logic [6:0]  shift_in;         // partial command byte
    logic [23:0] reply;            // answer, msb aligned at bit 23
    logic [7:0]  cmd_byte = 8'h00; // last command byte, read by clk_sys
    logic        cmd_toggle = 1'b0;// flips once per command byte
    logic        pick_meta_l = 1'b1; // protocol pick synchroniser
    logic        pick_link = 1'b1;
    logic        valid_meta_l = 1'b0; // result-valid synchroniser
    logic        valid_link = 1'b0;
    logic [7:0]  rx_byte;          // byte completed by this edge
    logic        spi_sel_l;        // spi chosen, link view

    assign rx_byte   = {shift_in, sdi};
    assign spi_sel_l = pick_link == `PICK_SPI_LEVEL;

    // build the answer for a command as it completes
    function automatic logic [23:0] build_reply(input logic [7:0] c,
                                               input logic       ok);
        logic [23:0] r;
        r = 24'h00_0000;
        case (sensor_pkg::decode_cmd(c))
            sensor_pkg::CMD_ADC_READ: begin
                // zero unless a fresh result waits
                r = ok ? adc_word : 24'h00_0000;
            end
            sensor_pkg::CMD_PROM_READ: begin
                // word sits in the top sixteen bits
                r = {prom[c[3:1]], 8'h00};
            end
            default: r = 24'h00_0000;
        endcase
        return r;
    endfunction

    // strap and flag synchronisers; sclk only runs inside frames, but
    // both levels are static long before a read needs them
    always_ff @(posedge sclk) begin
        pick_meta_l  <= protocol_pick;
        pick_link    <= pick_meta_l;
        valid_meta_l <= result_valid;
        valid_link   <= valid_meta_l;
    end

    // receive on rising edges, which both mode 0 and 3 sample on;
    // select high clears the frame so a partial byte is lost
    always_ff @(posedge sclk or posedge device_select_n) begin
        if (device_select_n) begin
            bit_cnt  <= 6'h00;
            shift_in <= 7'h00;
            reply    <= 24'h00_0000;
        end else begin
            shift_in <= rx_byte[6:0];
            if (bit_cnt != `FRAME_BITS_MAX) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
            if (bit_cnt == 6'h07 && spi_sel_l) begin
                reply <= build_reply(rx_byte, valid_link);
            end
        end
    end

    // hand the finished byte to clk_sys; not cleared by select so a
    // deselect can never fake an event
    always_ff @(posedge sclk) begin
        if (!device_select_n && bit_cnt == 6'h07 && spi_sel_l) begin
            cmd_byte   <= rx_byte;
            cmd_toggle <= ~cmd_toggle;
        end
    end

    // drive on falling edges, msb first; in mode 3 the idle-high clock
    // gives one extra falling edge first, which still sees zero bits
    always_ff @(negedge sclk or posedge device_select_n) begin
        if (device_select_n) begin
            sdo <= 1'b0;
        end else if (bit_cnt >= 6'h08 && bit_cnt < `FRAME_BITS_MAX &&
                     spi_sel_l) begin
            sdo <= reply[5'(6'h1f - bit_cnt)];
        end else begin
            sdo <= 1'b0;
        end
    end

    // ---------------- system domain (clk_sys) ----------------

    logic                    tog_meta;   // command toggle sync
    logic                    tog_sync;
    logic                    tog_seen;   // last toggle acted on
    logic                    pick_meta_s;// protocol pick sync
    logic                    pick_sys;
    logic                    cmd_event;  // one-cycle new command
    sensor_pkg::cmd_kind_t   kind;       // decoded command
    logic                    corrupt;    // running result is spoiled
    logic                    valid_set;  // result stored last cycle
    logic                    do_reset;   // reset command now
    logic                    do_conv;    // conversion command now
    logic                    do_read;    // adc read command now
    conv_if                  cif ();     // converter link

    // synchronise the link event; the toggle chain keeps tracking
    // through reset, because the link side has no reset and a cleared
    // chain would replay the last command byte after release
    always_ff @(posedge clk_sys) begin
        tog_meta <= cmd_toggle;
        tog_sync <= tog_meta;
        tog_seen <= tog_sync;
    end

    // synchronise the strap
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pick_meta_s <= 1'b0;
            pick_sys    <= 1'b0;
        end else begin
            pick_meta_s <= protocol_pick;
            pick_sys    <= pick_meta_s;
        end
    end

    // cmd_byte changed with cmd_toggle, so it has been stable for the two synchroniser cycles by now
    assign cmd_event = (tog_sync ^ tog_seen) &&
                       pick_sys == `PICK_SPI_LEVEL;
    assign kind      = sensor_pkg::decode_cmd(cmd_byte);
    assign do_reset  = cmd_event && kind == sensor_pkg::CMD_RESET;
    assign do_conv   = cmd_event && kind == sensor_pkg::CMD_CONV;
    assign do_read   = cmd_event && kind == sensor_pkg::CMD_ADC_READ;

    // memory is empty until the reset command loads it; this also
    // recovers it from any unknown state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < `PROM_WORDS; i++) begin
                prom[i] <= 16'h0000;
            end
        end else if (do_reset) begin
            // word 7 low nibble carries the check value
            for (int i = 0; i < `PROM_WORDS; i++) begin
                prom[i] <= PROM_IMAGE[i*16 +: 16];
            end
        end
    end

    // converter requests, one cycle each
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cif.start   <= 1'b0;
            cif.is_temp <= 1'b0;
            cif.oversampling_ratio     <= 3'h0;
            cif.abort   <= 1'b0;
        end else begin
            cif.start <= do_conv && !cif.busy;
            cif.abort <= do_reset;
            if (do_conv && !cif.busy) begin
                cif.is_temp <= cmd_byte[4];
                cif.oversampling_ratio     <= cmd_byte[3:1];
            end
        end
    end

    // a read or a second start during conversion spoils its result
    always_ff @(posedge clk_sys) begin
        if (reset || do_reset) begin
            corrupt <= 1'b0;
        end else if (cif.busy && (do_read || do_conv)) begin
            corrupt <= 1'b1;
        end else if (cif.start) begin
            corrupt <= 1'b0;
        end
    end

    // store the result first, raise valid a cycle later so the word
    // is settled before the link sees the flag
    always_ff @(posedge clk_sys) begin
        if (reset || do_reset) begin
            adc_word  <= 24'h00_0000;
            valid_set <= 1'b0;
        end else begin
            valid_set <= cif.done;
            if (cif.done) begin
                // inverted bits stand in for the wrong result
                adc_word <= corrupt ? ~cif.result : cif.result;
            end
        end
    end

    // result-valid: a completion wins over a same-cycle read or start clear, not over reset
    always_ff @(posedge clk_sys) begin
        if (reset || do_reset) begin
            result_valid <= 1'b0;
        end else if (valid_set) begin
            result_valid <= 1'b1;
        end else if (do_read || (do_conv && !cif.busy)) begin
            result_valid <= 1'b0;
        end
    end

    // busy status as a registered output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conversion_busy <= 1'b0;
        end else begin
            conversion_busy <= cif.busy;
        end
    end

    // conversion timing and sample capture
    conversion_timer #(
        .BASE_CYCLES (CONV_BASE_CYCLES)
    ) u_timer (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .cif                (cif),
        .pressure_sample    (pressure_sample),
        .temperature_sample (temperature_sample)
    );
endmodule

//--- design/sensor_regs.svh
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH
// Summary of operation
// - reset command accepted at any time
// - conversion picks pressure or temperature, runs deselected
// - adc result shifted out msb first
// - no conversion or repeated read reads zero
// - read during conversion: zero, continues, corrupted
// - eight 16-bit calibration words, 128 bits
// - memory read: command byte then 16-bit word
// - 4-bit check value kept inside memory
// - coefficient words one to six unsigned
// - device select active low gates the port
// - protocol pick chooses spi or i2c
// - pick low means spi, high i2c
// - spi modes 0 and 3 both work
// - single-byte commands with fixed encodings
// - adc read 24 bits, memory read 16

// command encodings
`define CMD_RESET_CODE      8'h1e
`define CMD_ADC_READ_CODE   8'h00
`define CMD_CONV_P_NIBBLE   4'h4
`define CMD_CONV_T_NIBBLE   4'h5
`define CMD_PROM_NIBBLE     4'ha
`define CMD_OSR_MAX         3'h4

// widths and sizes
`define CMD_BITS            8
`define PROM_WORDS          8
`define PROM_ADDR_BITS      3
`define PROM_WORD_BITS      16
`define ADC_BITS            24
`define CRC_BITS            4
`define REPLY_BITS          24
`define FRAME_BITS_MAX      6'h20

// calibration word addresses
`define PROM_FACTORY_ADDR   3'h0
`define PROM_COEFF_FIRST    3'h1
`define PROM_COEFF_LAST     3'h6
`define PROM_SERIAL_ADDR    3'h7

// protocol pick level that selects spi
`define PICK_SPI_LEVEL      1'b0
`endif

//--- design/sensor_pkg.sv
`include "sensor_regs.svh"
package sensor_pkg;
    // kind of a received command byte
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_RESET,
        CMD_CONV,
        CMD_ADC_READ,
        CMD_PROM_READ
    } cmd_kind_t;

    // converter sequencing
    typedef enum logic [0:0] {
        CONV_IDLE,
        CONV_RUN
    } conv_state_t;

    typedef logic [`PROM_WORD_BITS-1:0] prom_word_t;
    typedef logic [`ADC_BITS-1:0]       adc_word_t;

    // classify a command byte; used on both sides of the crossing
    function automatic cmd_kind_t decode_cmd(input logic [7:0] c);
        cmd_kind_t k;
        k = CMD_NONE;
        if (c == `CMD_RESET_CODE) begin
            k = CMD_RESET;
        end else if (c == `CMD_ADC_READ_CODE) begin
            k = CMD_ADC_READ;
        end else if ((c[7:4] == `CMD_CONV_P_NIBBLE ||
                      c[7:4] == `CMD_CONV_T_NIBBLE) &&
                     c[0] == 1'b0 && c[3:1] <= `CMD_OSR_MAX) begin
            k = CMD_CONV;
        end else if (c[7:4] == `CMD_PROM_NIBBLE && c[0] == 1'b0) begin
            k = CMD_PROM_READ;
        end
        return k;
    endfunction
endpackage

//--- design/conv_if.sv
`timescale 1ns/1ps
// control and result path between command logic and converter
interface conv_if;
    logic                     start;    // one-cycle start request
    logic                     is_temp;  // 1 temperature, 0 pressure
    logic [2:0]               oversampling_ratio;      // oversampling step 0..4
    logic                     abort;    // one-cycle stop from reset
    logic                     busy;     // conversion running
    logic                     done;     // one-cycle completion
    sensor_pkg::adc_word_t    result;   // valid with done
    modport ctrl (output start, is_temp, oversampling_ratio, abort,
                  input busy, done, result);
    modport conv (input start, is_temp, oversampling_ratio, abort,
                  output busy, done, result);
endinterface

//--- design/conversion_timer.sv
`timescale 1ns/1ps
// raw conversion timing; the analog front end hands in samples on clk_sys
module conversion_timer #(
    parameter int BASE_CYCLES = 2048
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    conv_if.conv                   cif,
    input  wire logic [23:0]       pressure_sample,
    input  wire logic [23:0]       temperature_sample
);
    initial begin
        if (BASE_CYCLES < 1 || BASE_CYCLES > 32'h0010_0000) begin
            $error("conversion_timer: BASE_CYCLES out of range");
        end
    end

    sensor_pkg::conv_state_t state;     // idle or running
    logic [31:0]             remaining; // cycles left
    logic                    temp_sel;  // latched selection

    // run one conversion; a start while running is ignored, which
    // keeps timing intact but the command logic marks the result bad
    always_ff @(posedge clk_sys) begin
        if (reset || cif.abort) begin
            state     <= sensor_pkg::CONV_IDLE;
            remaining <= 32'h0000_0000;
            temp_sel  <= 1'b0;
        end else begin
            case (state)
                sensor_pkg::CONV_IDLE: begin
                    if (cif.start) begin
                        // time doubles per oversampling step
                        state     <= sensor_pkg::CONV_RUN;
                        remaining <= 32'(BASE_CYCLES) << cif.oversampling_ratio;
                        temp_sel  <= cif.is_temp;
                    end
                end
                sensor_pkg::CONV_RUN: begin
                    if (remaining <= 32'h0000_0001) begin
                        state <= sensor_pkg::CONV_IDLE;
                    end
                    remaining <= remaining - 32'h0000_0001;
                end
                default: state <= sensor_pkg::CONV_IDLE;
            endcase
        end
    end

    // completion pulse with the selected sample
    always_ff @(posedge clk_sys) begin
        if (reset || cif.abort) begin
            cif.done   <= 1'b0;
            cif.result <= 24'h00_0000;
        end else begin
            cif.done <= state == sensor_pkg::CONV_RUN &&
                        remaining <= 32'h0000_0001;
            if (state == sensor_pkg::CONV_RUN &&
                remaining <= 32'h0000_0001) begin
                cif.result <= temp_sel ? temperature_sample
                                       : pressure_sample;
            end
        end
    end

    assign cif.busy = state == sensor_pkg::CONV_RUN;
endmodule

//--- verif/spi_master_model.sv
`timescale 1ns/1ps
// spi master stand-in; its clock runs only inside frames
module spi_master_model (
    output logic      sclk,
    output logic      device_select_n,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        device_select_n = 1'b1;
        sdi = 1'b0;
    end
    // one frame: command msb first, reply bits gathered after the eighth
    task automatic xfer(input logic [7:0] cmd, input int nbits,
                        input logic mode3, output logic [23:0] rep);
        logic [7:0] sh;
        sh = cmd;
        rep = 24'h00_0000;
        #7 sclk = mode3; // idle level picks mode 0 or 3
        #80 device_select_n = 1'b0; // select is active low
        for (int i = 0; i < nbits; i++) begin
            #80 sclk = 1'b0;
            // past the command byte sdi only toggles, carrying nothing
            sdi = (i < 8) ? sh[7] : ~sdi; // msb first
            sh = {sh[6:0], 1'b0};
            #80 sclk = 1'b1;
            if (i >= 8) rep = {rep[22:0], sdo};
        end
        #80 sclk = mode3;
        #160 device_select_n = 1'b1;
        sdi = ~sdi; // released line must not keep a stale value
        #400; // gap before the next command
    endtask
endmodule

//--- verif/cmd_port_properties.sv
`timescale 1ns/1ps
// pin-level checks of the command port
module cmd_port_checker #(
    parameter int CONV_BASE_CYCLES = 2048
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic sclk,
    input wire logic device_select_n,
    input wire logic protocol_pick,
    input wire logic sdo,
    input wire logic result_valid,
    input wire logic conversion_busy
);
    int         busy_len; // length of the current busy run
    logic [5:0] bit_cnt;  // sclk rising edges in this frame
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // busy run length, zero while idle
    always_ff @(posedge clk_sys) begin
        if (reset || !conversion_busy) busy_len <= 0;
        else busy_len <= busy_len + 1;
    end
    // frame bit count; deselect clears it at once
    always_ff @(posedge sclk or posedge device_select_n) begin
        if (device_select_n) bit_cnt <= 6'h0;
        else if (bit_cnt != 6'h3f) bit_cnt <= bit_cnt + 6'h1;
    end
    property p_sdo_desel;
        device_select_n && $past(device_select_n) |-> !sdo;
    endproperty
    a_sdo_desel: assert property (p_sdo_desel)
        else $error("sdo active while deselected");
    property p_pick_quiet;
        protocol_pick |-> !sdo;
    endproperty
    a_pick_quiet: assert property (p_pick_quiet)
        else $error("sdo active with i2c strap");
    property p_cmd_phase;
        !device_select_n && bit_cnt < 6'h8 |-> !sdo;
    endproperty
    a_cmd_phase: assert property (p_cmd_phase)
        else $error("sdo active during command byte");
    property p_reset_clear;
        $fell(reset) |-> !conversion_busy && !result_valid;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("flags set after reset");
    property p_valid_src;
        $rose(result_valid) |->
            $past(conversion_busy, 2) || $past(conversion_busy, 3);
    endproperty
    a_valid_src: assert property (p_valid_src)
        else $error("valid rose without a conversion end");
    property p_valid_excl;
        !(result_valid && conversion_busy);
    endproperty
    a_valid_excl: assert property (p_valid_excl)
        else $error("valid while converting");
    property p_busy_min;
        $fell(conversion_busy) |-> busy_len >= CONV_BASE_CYCLES;
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("conversion too short");
    property p_busy_max;
        $fell(conversion_busy) |-> busy_len <= CONV_BASE_CYCLES * 16 + 2;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("conversion too long");
endmodule
bind pressure_sensor_spi_command_port cmd_port_checker #(
    .CONV_BASE_CYCLES(CONV_BASE_CYCLES)
) chk_u (
    .clk_sys(clk_sys),
    .reset(reset),
    .sclk(sclk),
    .device_select_n(device_select_n),
    .protocol_pick(protocol_pick),
    .sdo(sdo),
    .result_valid(result_valid),
    .conversion_busy(conversion_busy)
);

//--- verif/pressure_sensor_spi_command_port_tb.sv
`timescale 1ns/1ps
// self-checking bench of the command port
module pressure_sensor_spi_command_port_tb;
    localparam int CONV_BASE = 8; // short conversions keep the run brief
    localparam logic [127:0] IMG =
        128'hc0de_7777_6666_5555_4444_3333_2222_1111;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [23:0] exp;
    } row_t;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        protocol_pick = 1'b0;
    logic [23:0] p_smp = 24'h00_0000; // pressure sample
    logic [23:0] t_smp = 24'h00_0000; // temperature sample
    logic        sclk, device_select_n, sdi, sdo;
    logic        result_valid, conversion_busy;
    logic [23:0] rep;
    row_t        rows [10];
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    pressure_sensor_spi_command_port #(
        .CONV_BASE_CYCLES(CONV_BASE), .PROM_IMAGE(IMG)
    ) dut_u (
        .clk_sys(clk_sys), .reset(reset), .sclk(sclk),
        .device_select_n(device_select_n), .sdi(sdi),
        .protocol_pick(protocol_pick), .pressure_sample(p_smp),
        .temperature_sample(t_smp), .sdo(sdo),
        .result_valid(result_valid), .conversion_busy(conversion_busy)
    );
    spi_master_model master_u (
        .sclk(sclk), .device_select_n(device_select_n),
        .sdi(sdi), .sdo(sdo)
    );
    always #25 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bounded wait on busy (sel 1) or valid (sel 0)
    task automatic wait_on(input logic sel, input logic lvl);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk_sys);
            if ((sel ? conversion_busy : result_valid) === lvl) return;
        end
        chk("wait", 24'h00_0001, 24'h00_0000);
    endtask
    initial begin
        for (int i = 0; i < 8; i++)
            rows[i] = '{8'ha0 + 8'(2 * i), {IMG[16*i +: 16], 8'h00}};
        rows[8] = '{8'h00, 24'h00_0000}; // read with no conversion
        rows[9] = '{8'h33, 24'h00_0000}; // unknown byte
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        master_u.xfer(8'h1e, 8, 1'b0, rep); // load words first
        foreach (rows[i]) begin
            master_u.xfer(rows[i].cmd, 32, i % 2 == 1, rep);
            chk("row", rep, rows[i].exp);
        end
        $display("table done");
        @(posedge clk_sys);
        p_smp <= 24'ha5_0f3c;
        t_smp <= 24'h3c_96e1;
        master_u.xfer(8'h40, 8, 1'b0, rep);
        wait_on(1'b0, 1'b1);
        master_u.xfer(8'h00, 32, 1'b1, rep);
        chk("pressure", rep, 24'ha5_0f3c);
        chk("valid", {23'h0, result_valid}, 24'h00_0000);
        master_u.xfer(8'h00, 32, 1'b0, rep);
        chk("repeat read", rep, 24'h00_0000);
        master_u.xfer(8'h58, 8, 1'b0, rep);
        wait_on(1'b1, 1'b1);
        master_u.xfer(8'h00, 32, 1'b0, rep);
        chk("busy read", rep, 24'h00_0000);
        wait_on(1'b0, 1'b1);
        master_u.xfer(8'h00, 32, 1'b1, rep);
        chk("temperature", rep, ~24'h3c_96e1);
        $display("conversion done");
        // a reset command in mid-conversion abandons it
        master_u.xfer(8'h48, 8, 1'b1, rep);
        wait_on(1'b1, 1'b1);
        master_u.xfer(8'h1e, 8, 1'b0, rep);
        repeat (150) @(posedge clk_sys);
        chk("abort", {22'h0, conversion_busy, result_valid}, 24'h0);
        // a half byte must not shift the next command
        master_u.xfer(8'ha4, 4, 1'b0, rep);
        master_u.xfer(8'ha4, 32, 1'b0, rep);
        chk("partial", rep, {IMG[47:32], 8'h00});
        @(posedge clk_sys) protocol_pick <= 1'b1;
        master_u.xfer(8'ha2, 32, 1'b0, rep);
        chk("i2c strap", rep, 24'h00_0000);
        @(posedge clk_sys) protocol_pick <= 1'b0;
        $display("abort, partial and strap done");
        master_u.xfer(8'h50, 8, 1'b0, rep);
        wait_on(1'b0, 1'b1);
        @(posedge clk_sys) reset <= 1'b1;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("reset", {22'h0, conversion_busy, result_valid}, 24'h0);
        master_u.xfer(8'ha2, 32, 1'b0, rep);
        chk("unloaded", rep, 24'h00_0000);
        master_u.xfer(8'h1e, 8, 1'b1, rep);
        master_u.xfer(8'ha2, 32, 1'b1, rep);
        chk("reloaded", rep, {IMG[31:16], 8'h00});
        $display("reset done");
        wrap_up();
    end
endmodule
